/* File: core/fifo_readout_consts.svh */
// constants of the measurement buffer readout block
`ifndef FIFO_READOUT_CONSTS_SVH
`define FIFO_READOUT_CONSTS_SVH
`define MFR_DEPTH_PEN 240
`define MFR_DEPTH_DOT 60
`define MFR_SETUP_OPMODE 3'h0
`define MFR_SETUP_DECUNIT 3'h1
`define MFR_SETUP_BASIC 3'h2
`define MFR_SETUP_FILE 3'h4
`define MFR_STAT_INST 3'h0
`define MFR_STAT_REPORT 3'h1
`define MFR_STAT_TIMER_ONE 3'h2
`define MFR_STAT_TIMER_TWO 3'h3
`define MFR_LATEST_TEXT 3'h0
`define MFR_ORDER_LSB_FIRST 1'b1
`endif

/* File: core/fifo_readout_pkg.sv */
// types shared by the measurement buffer readout block
package fifo_readout_pkg;
  typedef enum logic [2:0] {
    OP_GET,
    OP_REPEAT_LAST_TRANSFER,
    OP_RESET,
    OP_NEWEST_BLOCKS_READ,
    OP_LATEST,
    OP_SETUP,
    OP_STATS
  } op_t;
  typedef enum {
    ST_IDLE,
    ST_LOAD,
    ST_EMIT,
    ST_DRAIN
  } state_t;
endpackage

/* File: core/measurement_fifo_readout.sv */
// circular block buffer of acquired values with command driven byte stream readout
`include "fifo_readout_consts.svh"

// How it works
// - logging read sends up to n blocks after the last read, then advances.
// - repeat_last_transfer replays the preceding buffer output; read position untouched.
// - pointer reset puts the read position just after the newest acquired block.
// - newest read sends up to n blocks counting back from the newest block.
// - buffer holds 240 blocks (pen) or 60 blocks (dot).
// - full buffer: each new block overwrites the oldest one.
// - count limit omitted: logging read sends every unread block, newest read every block held.
// - count only used by logging and newest reads; range used by all but repeat, pointer reset and file setup.
// - one range may span measurement into computation channels.
// - latest data is taken at request time; text for type 0, else binary.
// - setup type 0 mode, 1 decimal and unit, 2 basic, 4 settings file.
// - setup channel range applies to types 0, 1, 2; ignored for file.
// - statistics type picks instantaneous, report, timer one or two capture.
// - timer capture types only when the computation option is fitted.
// - one block is written per acquisition tick.
// - binary values go MSB first for order 0, LSB first for order 1.
module measurement_fifo_readout #(
  parameter bit DOT_VARIANT = 1'b0,
  parameter int NCH = 32,
  parameter int VW = 16,
  localparam int DEPTH = DOT_VARIANT ? `MFR_DEPTH_DOT : `MFR_DEPTH_PEN,
  localparam int CW = $clog2(NCH),
  localparam int AW = $clog2(DEPTH)
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic meas_valid,
  input wire logic [CW-1:0] meas_ch,
  input wire logic [VW-1:0] meas_value,
  input wire logic acquire_tick,
  input wire logic byte_order,
  input wire logic comp_fitted,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire fifo_readout_pkg::op_t cmd_op,
  input wire logic [2:0] cmd_type,
  input wire logic [CW-1:0] cmd_first,
  input wire logic [CW-1:0] cmd_last,
  input wire logic [AW:0] cmd_count,
  input wire logic cmd_count_given,
  output logic aux_is_stats,
  output logic [2:0] aux_type,
  output logic [CW-1:0] aux_ch,
  input wire logic [VW-1:0] aux_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [7:0] out_data,
  output logic out_last,
  output logic cmd_done,
  output logic cmd_error
);
  import fifo_readout_pkg::*;

  localparam int NB = VW / 8;
  localparam int NT = VW / 4;
  localparam int BIW = $clog2(NT);
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

  logic [NCH*VW-1:0] buf_mem [DEPTH];
  logic [NCH*VW-1:0] live_q, row_q;
  logic [AW-1:0] wr_q, wr_d, nxt_q, nxt_d, blk_idx_q;
  logic [AW:0] cnt_q, cnt_d, unr_q, unr_d, blk_left_q;
  logic [AW-1:0] t_nxt, g_start, lst_start_q;
  logic [AW:0] t_cnt, t_unr, req, g_n, lst_n_q;
  logic [CW-1:0] first_q, last_q, ch_q, lst_first_q, lst_last_q;
  logic [BIW-1:0] bi_q;
  logic use_aux_q, txt_q, bo_q, ov_q, last_q_out, done_q, err_q;
  logic [7:0] data_q, byte_sel;
  logic [VW-1:0] cur_val;
  logic accept, fire, last_byte, last_ch, last_blk;
  state_t state_q;

  function automatic logic [AW-1:0] wrap(input logic [AW-1:0] a, input logic [AW:0] b);
    logic [AW+1:0] s;
    s = {2'b00, a} + {1'b0, b};
    if (s >= {1'b0, DEPTH_C})
      s = s - {1'b0, DEPTH_C};
    return s[AW-1:0];
  endfunction

  function automatic logic [AW:0] min_cnt(input logic [AW:0] a, input logic [AW:0] b);
    return (a < b) ? a : b;
  endfunction

  function automatic logic [7:0] hex_char(input logic [3:0] n);
    return (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h57 + {4'h0, n});
  endfunction

  assign cmd_ready = (state_q == ST_IDLE);
  assign accept = cmd_valid && cmd_ready;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      live_q <= '0;
    else if (meas_valid)
      live_q[meas_ch*VW +: VW] <= meas_value;
  end

  // one block per tick; memory has no reset, stale slots are never counted as held
  always_ff @(posedge clk)
  begin
    if (acquire_tick)
      buf_mem[wr_q] <= live_q;
  end

  always_comb
  begin
    wr_d = wr_q;
    t_cnt = cnt_q;
    t_nxt = nxt_q;
    t_unr = unr_q;
    if (acquire_tick)
    begin
      wr_d = wrap(wr_q, (AW+1)'(1));
      if (cnt_q != DEPTH_C)
        t_cnt = cnt_q + (AW+1)'(1);
      if (unr_q == DEPTH_C)
        t_nxt = wrap(nxt_q, (AW+1)'(1));
      else
        t_unr = unr_q + (AW+1)'(1);
    end
    req = cmd_count_given ? cmd_count : DEPTH_C;
    g_n = min_cnt(req, (cmd_op == OP_GET) ? t_unr : t_cnt);
    g_start = (cmd_op == OP_GET) ? t_nxt : wrap(wr_d, DEPTH_C - g_n);
    cnt_d = t_cnt;
    nxt_d = t_nxt;
    unr_d = t_unr;
    if (accept && cmd_op == OP_GET)
    begin
      nxt_d = wrap(t_nxt, g_n);
      unr_d = t_unr - g_n;
    end
    else if (accept && cmd_op == OP_RESET)
    begin
      nxt_d = wr_d;
      unr_d = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wr_q <= '0;
      cnt_q <= '0;
      nxt_q <= '0;
      unr_q <= '0;
    end
    else
    begin
      wr_q <= wr_d;
      cnt_q <= cnt_d;
      nxt_q <= nxt_d;
      unr_q <= unr_d;
    end
  end

  assign cur_val = use_aux_q ? aux_data : row_q[ch_q*VW +: VW];
  assign last_byte = (bi_q == (txt_q ? BIW'(NT-1) : BIW'(NB-1)));
  assign last_ch = (ch_q == last_q);
  assign last_blk = (blk_left_q == (AW+1)'(1));
  assign fire = (state_q == ST_EMIT) && (!ov_q || out_ready);

  always_comb
  begin
    if (txt_q)
      byte_sel = hex_char(cur_val[(NT-1-int'(bi_q))*4 +: 4]);
    else if (bo_q == `MFR_ORDER_LSB_FIRST)
      byte_sel = cur_val[int'(bi_q)*8 +: 8];
    else
      byte_sel = cur_val[(NB-1-int'(bi_q))*8 +: 8];
  end

  // transfer sequencing; aux values are read live, so the source must hold them steady
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_q <= ST_IDLE;
      row_q <= '0;
      use_aux_q <= 1'b0;
      txt_q <= 1'b0;
      bo_q <= 1'b0;
      first_q <= '0;
      last_q <= '0;
      ch_q <= '0;
      bi_q <= '0;
      blk_idx_q <= '0;
      blk_left_q <= '0;
      aux_is_stats <= 1'b0;
      aux_type <= '0;
      lst_start_q <= '0;
      lst_n_q <= '0;
      lst_first_q <= '0;
      lst_last_q <= '0;
      done_q <= 1'b0;
      err_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      err_q <= 1'b0;
      unique case (state_q)
        ST_IDLE:
        begin
          if (accept)
          begin
            bo_q <= byte_order;
            txt_q <= 1'b0;
            use_aux_q <= 1'b0;
            first_q <= cmd_first;
            last_q <= cmd_last;
            ch_q <= cmd_first;
            bi_q <= '0;
            blk_left_q <= (AW+1)'(1);
            unique case (cmd_op)
              OP_GET, OP_NEWEST_BLOCKS_READ:
              begin
                lst_start_q <= g_start;
                lst_n_q <= g_n;
                lst_first_q <= cmd_first;
                lst_last_q <= cmd_last;
                blk_idx_q <= g_start;
                blk_left_q <= g_n;
                if (g_n == '0)
                  done_q <= 1'b1;
                else
                  state_q <= ST_LOAD;
              end
              OP_REPEAT_LAST_TRANSFER:
              begin
                blk_idx_q <= lst_start_q;
                blk_left_q <= lst_n_q;
                first_q <= lst_first_q;
                last_q <= lst_last_q;
                ch_q <= lst_first_q;
                if (lst_n_q == '0)
                  done_q <= 1'b1;
                else
                  state_q <= ST_LOAD;
              end
              OP_RESET:
                done_q <= 1'b1;
              OP_LATEST:
              begin
                row_q <= live_q;
                txt_q <= (cmd_type == `MFR_LATEST_TEXT);
                state_q <= ST_EMIT;
              end
              OP_SETUP:
              begin
                aux_is_stats <= 1'b0;
                aux_type <= cmd_type;
                use_aux_q <= 1'b1;
                if (cmd_type == `MFR_SETUP_FILE)
                begin
                  first_q <= '0;
                  ch_q <= '0;
                  last_q <= CW'(NCH-1);
                end
                if (cmd_type == `MFR_SETUP_OPMODE || cmd_type == `MFR_SETUP_DECUNIT ||
                    cmd_type == `MFR_SETUP_BASIC || cmd_type == `MFR_SETUP_FILE)
                  state_q <= ST_EMIT;
                else
                  err_q <= 1'b1;
              end
              OP_STATS:
              begin
                aux_is_stats <= 1'b1;
                aux_type <= cmd_type;
                use_aux_q <= 1'b1;
                if (cmd_type == `MFR_STAT_INST || cmd_type == `MFR_STAT_REPORT)
                  state_q <= ST_EMIT;
                else if ((cmd_type == `MFR_STAT_TIMER_ONE || cmd_type == `MFR_STAT_TIMER_TWO)
                         && comp_fitted)
                  state_q <= ST_EMIT;
                else
                  err_q <= 1'b1;
              end
              default:
                err_q <= 1'b1;
            endcase
          end
        end
        ST_LOAD:
        begin
          row_q <= buf_mem[blk_idx_q];
          ch_q <= first_q;
          bi_q <= '0;
          state_q <= ST_EMIT;
        end
        ST_EMIT:
        begin
          if (fire)
          begin
            if (!last_byte)
              bi_q <= bi_q + BIW'(1);
            else if (!last_ch)
            begin
              bi_q <= '0;
              ch_q <= ch_q + CW'(1);
            end
            else if (last_blk)
              state_q <= ST_DRAIN;
            else
            begin
              blk_idx_q <= wrap(blk_idx_q, (AW+1)'(1));
              blk_left_q <= blk_left_q - (AW+1)'(1);
              state_q <= ST_LOAD;
            end
          end
        end
        ST_DRAIN:
        begin
          if (out_ready)
          begin
            done_q <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ov_q <= 1'b0;
      data_q <= '0;
      last_q_out <= 1'b0;
    end
    else if (fire)
    begin
      ov_q <= 1'b1;
      data_q <= byte_sel;
      last_q_out <= last_byte && last_ch && last_blk;
    end
    else if (out_ready)
      ov_q <= 1'b0;
  end

  assign aux_ch = ch_q;
  assign out_valid = ov_q;
  assign out_data = data_q;
  assign out_last = last_q_out;
  assign cmd_done = done_q;
  assign cmd_error = err_q;
endmodule

/* File: bench/measurement_fifo_readout_asserts.sv */
// checker of the readout command and stream handshakes
module measurement_fifo_readout_asserts import fifo_readout_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic comp_fitted,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire fifo_readout_pkg::op_t cmd_op,
  input wire logic [2:0] cmd_type,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [7:0] out_data,
  input wire logic out_last,
  input wire logic cmd_done,
  input wire logic cmd_error
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  logic acc;
  assign acc = cmd_valid && cmd_ready;
  a_busy_while_stream: assert property (out_valid |-> !cmd_ready)
    else $error("ready while streaming");
  a_stream_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("stalled byte changed");
  a_done_after_last: assert property (out_valid && out_last && out_ready |=> cmd_done && !out_valid)
    else $error("no done after last byte");
  // an empty command may be taken while the previous done pulse still stands
  a_done_one_cycle: assert property (cmd_done && !acc |=> !cmd_done)
    else $error("done too long");
  a_reset_done: assert property (acc && cmd_op == OP_RESET |=> cmd_done && !out_valid)
    else $error("pointer reset not done");
  a_setup_bad_type: assert property (acc && cmd_op == OP_SETUP && cmd_type inside {3'h3, 3'h5}
    |=> cmd_error)
    else $error("bad setup type taken");
  a_timer_needs_opt: assert property (acc && cmd_op == OP_STATS && cmd_type inside {3'h2, 3'h3}
    && !comp_fitted |=> cmd_error)
    else $error("timer type without option");
  a_latest_prompt: assert property (acc && cmd_op == OP_LATEST |-> ##[1:4] out_valid)
    else $error("latest data late");
  c_get: cover property (acc && cmd_op == OP_GET);
  c_last: cover property (out_valid && out_last && out_ready);
  c_err: cover property (cmd_error);
endmodule
bind measurement_fifo_readout measurement_fifo_readout_asserts chk_u (.clk, .sys_rst,
  .comp_fitted, .cmd_valid, .cmd_ready, .cmd_op, .cmd_type, .out_valid, .out_ready,
  .out_data, .out_last, .cmd_done, .cmd_error);

/* File: bench/host_side_model.sv */
// host side model: stalling byte sink and setup/statistics store
module host_side_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic slow,
  input wire logic aux_is_stats,
  input wire logic [2:0] aux_type,
  input wire logic [4:0] aux_ch,
  output logic [15:0] aux_data,
  output logic out_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_q;
  // store content encodes its own address so every wrong read shows
  assign aux_data = {4'ha, aux_is_stats, aux_type, 3'h0, aux_ch};
  assign out_ready = slow ? cnt_q == 2'h0 : cnt_q != 2'h3;
  always_ff @(posedge clk)
    cnt_q <= sys_rst ? 2'h0 : cnt_q + 2'h1;
endmodule

/* File: bench/test_measurement_fifo_readout.sv */
// self-checking bench of the measurement buffer readout block
module test_measurement_fifo_readout import fifo_readout_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, sys_rst = 1, meas_valid = 0, acquire_tick = 0, byte_order = 0;
  logic comp_fitted = 0, cmd_valid = 0, cmd_count_given = 0, slow = 0, err;
  logic cmd_ready, aux_is_stats, out_valid, out_ready, out_last, cmd_done, cmd_error;
  logic [4:0] meas_ch = 0, cmd_first = 0, cmd_last = 0, aux_ch;
  logic [15:0] meas_value = 0, aux_data;
  logic [6:0] cmd_count = 0;
  logic [2:0] cmd_type = 0, aux_type;
  logic [7:0] out_data;
  op_t cmd_op = OP_GET;
  logic [7:0] q[$], e[$];
  int n_mismatch = 0, tests_run = 0;
  int n_last = 0, last_at = 0;
  initial
    forever #2 clk = ~clk;
  // dot variant keeps the wrap test short
  measurement_fifo_readout #(.DOT_VARIANT(1'b1)) dut_u (.clk, .sys_rst, .meas_valid,
    .meas_ch, .meas_value, .acquire_tick, .byte_order, .comp_fitted, .cmd_valid,
    .cmd_ready, .cmd_op, .cmd_type, .cmd_first, .cmd_last, .cmd_count, .cmd_count_given,
    .aux_is_stats, .aux_type, .aux_ch, .aux_data, .out_valid, .out_ready, .out_data,
    .out_last, .cmd_done, .cmd_error);
  host_side_model host_u (.clk, .sys_rst, .slow, .aux_is_stats, .aux_type, .aux_ch,
    .aux_data, .out_ready);
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, x);
    tests_run++;
    if (g !== x)
    begin
      n_mismatch++;
      $display("Error at %0t got %h expected %h", $time, g, x);
    end
  endtask
  task automatic cmpq();
    chk(16'(q.size()), 16'(e.size()));
    foreach (e[i])
      if (i < q.size())
        chk(q[i], e[i]);
    if (e.size() > 0)
      chk({8'(n_last), 8'(last_at)}, {8'h1, 8'(e.size())});
    e = {};
  endtask
  function automatic logic [15:0] v(input int k, c);
    return 16'(k * 256 + c + 16);
  endfunction
  task automatic expv(input logic [15:0] x);
    if (byte_order)
      e = {e, x[7:0], x[15:8]};
    else
      e = {e, x[15:8], x[7:0]};
  endtask
  task automatic expb(input int k0, k1, c0, c1);
    for (int k = k0; k <= k1; k++)
      for (int c = c0; c <= c1; c++)
        expv(v(k, c));
  endtask
  task automatic acq(input int k);
    for (int c = 0; c < 4; c++)
    begin
      @(negedge clk);
      meas_valid = 1;
      meas_ch = 5'(c);
      meas_value = v(k, c);
    end
    @(negedge clk);
    meas_valid = 0;
    acquire_tick = 1;
    @(negedge clk);
    acquire_tick = 0;
  endtask
  // range and count kept legal by the host side
  task automatic run(input op_t op, input int ty, f, l, n, g);
    int t;
    // one edge between commands so cmd_valid is never set twice in one step
    @(negedge clk);
    for (t = 0; t < 50 && cmd_ready !== 1'b1; t++)
      @(negedge clk);
    if (cmd_ready !== 1'b1)
    begin
      n_mismatch++;
      conclude();
    end
    cmd_op = op;
    cmd_type = 3'(ty);
    cmd_first = 5'(f);
    cmd_last = 5'(l);
    cmd_count = 7'(n);
    cmd_count_given = g[0];
    cmd_valid = 1;
    q = {};
    n_last = 0;
    last_at = 0;
    @(negedge clk);
    cmd_valid = 0;
    for (t = 0; t < 3000 && !(cmd_done || cmd_error); t++)
    begin
      @(negedge clk);
      if (out_valid && out_ready)
      begin
        q.push_back(out_data);
        if (out_last)
        begin
          n_last++;
          last_at = q.size();
        end
      end
    end
    err = cmd_error;
    if (t == 3000)
    begin
      n_mismatch++;
      conclude();
    end
  endtask
  task automatic s_get();
    for (int k = 1; k < 4; k++)
      acq(k);
    run(OP_GET, 0, 1, 2, 2, 1);
    expb(1, 2, 1, 2);
    cmpq();
  endtask
  task automatic s_repeat_last_transfer();
    run(OP_REPEAT_LAST_TRANSFER, 0, 0, 3, 1, 1);
    expb(1, 2, 1, 2);
    cmpq();
    run(OP_GET, 0, 0, 3, 0, 0);
    expb(3, 3, 0, 3);
    cmpq();
    acq(4);
    run(OP_GET, 0, 0, 0, 5, 1);
    expb(4, 4, 0, 0);
    cmpq();
  endtask
  task automatic s_newest();
    byte_order = 1;
    slow = 1;
    run(OP_NEWEST_BLOCKS_READ, 0, 3, 3, 2, 1);
    expb(3, 4, 3, 3);
    cmpq();
    byte_order = 0;
    slow = 0;
  endtask
  task automatic s_reset();
    acq(5);
    run(OP_RESET, 0, 0, 3, 9, 1);
    cmpq();
    run(OP_GET, 0, 0, 1, 0, 0);
    cmpq();
    acq(6);
    run(OP_GET, 0, 0, 1, 0, 0);
    expb(6, 6, 0, 1);
    cmpq();
  endtask
  task automatic s_wrap();
    for (int k = 10; k < 72; k++)
      acq(k);
    run(OP_GET, 0, 0, 0, 0, 0);
    expb(12, 71, 0, 0);
    cmpq();
  endtask
  task automatic s_aux();
    run(OP_LATEST, 0, 2, 2, 0, 0);
    e = {8'h34, 8'h37, 8'h31, 8'h32};
    cmpq();
    run(OP_LATEST, 1, 2, 3, 0, 0);
    expb(71, 71, 2, 3);
    cmpq();
    run(OP_STATS, 2, 1, 1, 0, 0);
    chk(16'(err), 16'h1);
    run(OP_SETUP, 3, 1, 1, 0, 0);
    chk(16'(err), 16'h1);
    comp_fitted = 1;
    run(OP_STATS, 2, 1, 1, 0, 0);
    expv({4'ha, 1'b1, 3'h2, 3'h0, 5'h1});
    cmpq();
    for (int ty = 0; ty < 4; ty++)
    begin
      run(OP_STATS, ty, 4, 5, 0, 0);
      for (int c = 4; c < 6; c++)
        expv({4'ha, 1'b1, 3'(ty), 3'h0, 5'(c)});
      cmpq();
    end
    for (int ty = 0; ty < 3; ty++)
    begin
      run(OP_SETUP, ty, 2, 3, 0, 0);
      for (int c = 2; c < 4; c++)
        expv({4'ha, 1'b0, 3'(ty), 3'h0, 5'(c)});
      cmpq();
    end
    run(OP_SETUP, 4, 3, 3, 0, 0);
    for (int c = 0; c < 32; c++)
      expv({8'ha4, 3'h0, 5'(c)});
    cmpq();
  endtask
  initial
  begin
    repeat (20) @(negedge clk);
    sys_rst = 0;
    s_get();
    s_repeat_last_transfer();
    s_newest();
    s_reset();
    s_wrap();
    s_aux();
    conclude();
  end
endmodule
